// ### core/dlwc_pkg.sv
// display layer window config: shared constants, types and register map
// assumes byte offsets relative to the display register base on the plain port
package dlwc_pkg;

	// ==========================================================
	// bus and register widths
	localparam int ADDR_W = 9;
	localparam int DATA_W = 32;
	localparam int ADDR_FIELD_W = 26;

	// ==========================================================
	// register byte offsets from the display register base
	localparam logic [8:0] OFF_OVB_MODE     = 9'h088;
	localparam logic [8:0] OFF_OVB_ORIGIN0  = 9'h08c;
	localparam logic [8:0] OFF_OVB_DISP0    = 9'h090;
	localparam logic [8:0] OFF_OVB_ORIGIN1  = 9'h094;
	localparam logic [8:0] OFF_OVA_WIN_Y    = 9'h156;
	localparam logic [8:0] OFF_OVA_WIN_W    = 9'h158;
	localparam logic [8:0] OFF_OVA_WIN_H    = 9'h15a;
	localparam logic [8:0] OFF_OVB_EXT_MODE = 9'h160;

	// ==========================================================
	// field positions
	localparam int WIN_FIELD_W = 12;
	localparam int MODE_HEIGHT_LSB = 0;
	localparam int MODE_HEIGHT_W = 12;
	localparam int MODE_STRIDE_LSB = 16;
	localparam int MODE_STRIDE_W = 8;
	localparam int MODE_FLIP_LSB = 29;
	localparam int MODE_COLOUR_BIT = 31;
	localparam int EXT_PLACE_BIT = 0;
	localparam int EXT_OVERLAY_BIT = 1;
	localparam int EXT_PALETTE_LSB = 20;
	localparam int EXT_PALETTE_W = 4;
	localparam int EXT_COLOUR_LSB = 30;
	localparam int ORIGIN_ALIGN_BITS = 4;
	localparam int STRIDE_UNIT_SHIFT = 6;
	localparam int PALETTE_UNIT_SHIFT = 4;

	// ==========================================================
	// reset values
	localparam logic [31:0] RST_OVB_MODE = 32'h0000_0000;
	localparam logic [31:0] RST_OVB_EXT_MODE = 32'h0000_0000;
	localparam logic [25:0] RST_ADDR = 26'h000_0000;
	localparam logic [11:0] RST_WIN = 12'h000;

	// ==========================================================
	// modes
	typedef enum logic [1:0] {
		FLIP_FRAME0 = 2'b00,
		FLIP_FRAME1 = 2'b01,
		FLIP_ALTERNATE = 2'b10,
		FLIP_RESERVED = 2'b11
	} dlwc_flip_type;

	typedef enum logic [1:0] {
		PIX_IDX8 = 2'b00,
		PIX_DIR16 = 2'b01,
		PIX_DIR24 = 2'b10,
		PIX_RESERVED = 2'b11
	} dlwc_pix_fmt_type;

	localparam logic [1:0] EXT_COLOUR_BASIC = 2'b00;
	localparam logic [1:0] EXT_COLOUR_DIR24 = 2'b01;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [8:0]        addr;
		logic [31:0]       wdata;
	} dlwc_bus_req_type;

	typedef struct packed {
		logic [12:0]       frame_lines;
		logic [13:0]       stride_bytes;
		dlwc_pix_fmt_type  pix_fmt;
		logic              place_window;
		logic              overlay_ext;
		logic [7:0]        palette_offset;
		logic              show_frame1;
		logic [25:0]       fetch_origin;
		logic [25:0]       disp_addr0;
	} dlwc_ovb_cfg_type;

endpackage : dlwc_pkg

// ### core/dlwc_frame_sel.sv
// display layer window config: shown-frame selector for the second overlay
// assumes FRAME_START is a one-cycle pulse at each displayed frame boundary
`timescale 1ns/100ps
module dlwc_frame_sel (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire dlwc_pkg::dlwc_flip_type flip_mode,
	input  wire logic                   frame_start,
	output logic                        show_frame1_q
);
	import dlwc_pkg::*;

	logic show_frame1_d;

	// ==========================================================
	// next shown frame, only changed at a frame boundary
	always_comb begin
		show_frame1_d = show_frame1_q;
		if (frame_start) begin
			case (flip_mode)
				FLIP_FRAME0: show_frame1_d = 1'b0;
				FLIP_FRAME1: show_frame1_d = 1'b1;
				FLIP_ALTERNATE: show_frame1_d = ~show_frame1_q;
				default: show_frame1_d = show_frame1_q;   // reserved code holds
			endcase
		end
	end

	// shown frame flag
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			show_frame1_q <= 1'b0;
		end else begin
			show_frame1_q <= show_frame1_d;
		end
	end

endmodule : dlwc_frame_sel

// ### core/dlwc_regs.sv
// display layer window config: register bank for two overlay layers
// assumes a single 25 MHz clock, synchronous active-low reset, plain register port
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module dlwc_regs (
	input  wire logic                      CLK,
	input  wire logic                      RST_N,
	input  wire dlwc_pkg::dlwc_bus_req_type BUS_REQ,
	input  wire logic                      FRAME_START,
	output logic [31:0]                    RDATA,
	output logic [11:0]                    OVA_WIN_Y,
	output logic [11:0]                    OVA_WIN_W,
	output logic [12:0]                    OVA_WIN_LINES,
	output logic                           OVA_WIDTH_ZERO,
	output dlwc_pkg::dlwc_ovb_cfg_type     OVB_CFG
);
	import dlwc_pkg::*;

	// ==========================================================
	// storage
	logic [11:0] ova_win_y_q;
	logic [11:0] ova_win_w_q;
	logic [11:0] ova_win_h_q;
	logic [11:0] ovb_height_q;
	logic [7:0]  ovb_stride_q;
	logic [1:0]  ovb_flip_q;
	logic        ovb_colour_q;
	logic        ovb_place_q;
	logic        ovb_overlay_q;
	logic [3:0]  ovb_palette_q;
	logic [1:0]  ovb_ext_colour_q;
	logic [21:0] ovb_origin0_q;
	logic [25:0] ovb_disp0_q;
	logic [21:0] ovb_origin1_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [11:0] ova_win_y_out_q;
	logic [11:0] ova_win_w_out_q;
	logic [12:0] ova_win_lines_q;
	logic        ova_width_zero_q;
	dlwc_ovb_cfg_type ovb_cfg_q;
	dlwc_ovb_cfg_type ovb_cfg_d;
	logic        show_frame1;

	// ==========================================================
	// address decode
	wire wr_en = BUS_REQ.wr;
	wire rd_en = BUS_REQ.rd;
	wire [31:0] wd = BUS_REQ.wdata;
	wire hit_mode = (BUS_REQ.addr == OFF_OVB_MODE);
	wire hit_org0 = (BUS_REQ.addr == OFF_OVB_ORIGIN0);
	wire hit_disp0 = (BUS_REQ.addr == OFF_OVB_DISP0);
	wire hit_org1 = (BUS_REQ.addr == OFF_OVB_ORIGIN1);
	wire hit_wy = (BUS_REQ.addr == OFF_OVA_WIN_Y);
	wire hit_ww = (BUS_REQ.addr == OFF_OVA_WIN_W);
	wire hit_wh = (BUS_REQ.addr == OFF_OVA_WIN_H);
	wire hit_ext = (BUS_REQ.addr == OFF_OVB_EXT_MODE);

	// write field slices
	wire [11:0] wd_win = wd[WIN_FIELD_W-1:0];
	wire [11:0] wd_height = wd[MODE_HEIGHT_LSB +: MODE_HEIGHT_W];
	wire [7:0]  wd_stride = wd[MODE_STRIDE_LSB +: MODE_STRIDE_W];
	wire [1:0]  wd_flip = wd[MODE_FLIP_LSB +: 2];
	wire        wd_colour = wd[MODE_COLOUR_BIT];
	wire        wd_place = wd[EXT_PLACE_BIT];
	wire        wd_overlay = wd[EXT_OVERLAY_BIT];
	wire [3:0]  wd_palette = wd[EXT_PALETTE_LSB +: EXT_PALETTE_W];
	wire [1:0]  wd_ext_colour = wd[EXT_COLOUR_LSB +: 2];
	wire [21:0] wd_origin = wd[ADDR_FIELD_W-1:ORIGIN_ALIGN_BITS];
	wire [25:0] wd_addr = wd[ADDR_FIELD_W-1:0];

	// ==========================================================
	// colour format resolution
	wire ext_dir24 = (ovb_ext_colour_q == EXT_COLOUR_DIR24);
	wire ext_rsvd = ovb_ext_colour_q[1];
	wire basic_dir16 = ovb_colour_q;
	wire is_dir16 = (ovb_ext_colour_q == EXT_COLOUR_BASIC) && basic_dir16;
	wire dlwc_pix_fmt_type pix_fmt = ext_rsvd ? PIX_RESERVED :
	                                 ext_dir24 ? PIX_DIR24 :
	                                 basic_dir16 ? PIX_DIR16 : PIX_IDX8;

	// display address with 2-byte alignment in 16-bit direct colour
	wire [25:0] disp0_view = {ovb_disp0_q[25:1], ovb_disp0_q[0] & ~is_dir16};

	// aligned origin addresses
	wire [25:0] origin0_view = {ovb_origin0_q, 4'h0};
	wire [25:0] origin1_view = {ovb_origin1_q, 4'h0};

	// ==========================================================
	// readback words, reserved bits zero
	wire [31:0] rd_mode = {ovb_colour_q, ovb_flip_q, 5'h00, ovb_stride_q,
	                       4'h0, ovb_height_q};
	wire [31:0] rd_ext = {ovb_ext_colour_q, 6'h00, ovb_palette_q, 18'h00000,
	                      ovb_overlay_q, ovb_place_q};
	wire [31:0] rd_org0 = {6'h00, origin0_view};
	wire [31:0] rd_disp0 = {6'h00, disp0_view};
	wire [31:0] rd_org1 = {6'h00, origin1_view};
	wire [31:0] rd_wy = {20'h00000, ova_win_y_q};
	wire [31:0] rd_ww = {20'h00000, ova_win_w_q};
	wire [31:0] rd_wh = {20'h00000, ova_win_h_q};

	// read mux, unmapped and idle cycles read zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (rd_en) begin
			case (1'b1)
				hit_mode: rdata_d = rd_mode;
				hit_org0: rdata_d = rd_org0;
				hit_disp0: rdata_d = rd_disp0;
				hit_org1: rdata_d = rd_org1;
				hit_wy: rdata_d = rd_wy;
				hit_ww: rdata_d = rd_ww;
				hit_wh: rdata_d = rd_wh;
				hit_ext: rdata_d = rd_ext;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// first overlay window registers
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ova_win_y_q <= RST_WIN;
			ova_win_w_q <= RST_WIN;
			ova_win_h_q <= RST_WIN;
		end else begin
			if (wr_en && hit_wy) ova_win_y_q <= wd_win;
			if (wr_en && hit_ww) ova_win_w_q <= wd_win;
			if (wr_en && hit_wh) ova_win_h_q <= wd_win;
		end
	end

	// second overlay mode register
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ovb_height_q <= RST_OVB_MODE[MODE_HEIGHT_LSB +: MODE_HEIGHT_W];
			ovb_stride_q <= RST_OVB_MODE[MODE_STRIDE_LSB +: MODE_STRIDE_W];
			ovb_flip_q <= RST_OVB_MODE[MODE_FLIP_LSB +: 2];
			ovb_colour_q <= RST_OVB_MODE[MODE_COLOUR_BIT];
		end else if (wr_en && hit_mode) begin
			ovb_height_q <= wd_height;
			ovb_stride_q <= wd_stride;
			ovb_flip_q <= wd_flip;
			ovb_colour_q <= wd_colour;
		end
	end

	// second overlay extended mode register
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ovb_place_q <= RST_OVB_EXT_MODE[EXT_PLACE_BIT];
			ovb_overlay_q <= RST_OVB_EXT_MODE[EXT_OVERLAY_BIT];
			ovb_palette_q <= RST_OVB_EXT_MODE[EXT_PALETTE_LSB +: EXT_PALETTE_W];
			ovb_ext_colour_q <= RST_OVB_EXT_MODE[EXT_COLOUR_LSB +: 2];
		end else if (wr_en && hit_ext) begin
			ovb_place_q <= wd_place;
			ovb_overlay_q <= wd_overlay;
			ovb_palette_q <= wd_palette;
			ovb_ext_colour_q <= wd_ext_colour;
		end
	end

	// second overlay address registers
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ovb_origin0_q <= RST_ADDR[ADDR_FIELD_W-1:ORIGIN_ALIGN_BITS];
			ovb_disp0_q <= RST_ADDR;
			ovb_origin1_q <= RST_ADDR[ADDR_FIELD_W-1:ORIGIN_ALIGN_BITS];
		end else begin
			if (wr_en && hit_org0) ovb_origin0_q <= wd_origin;
			if (wr_en && hit_disp0) ovb_disp0_q <= wd_addr;
			if (wr_en && hit_org1) ovb_origin1_q <= wd_origin;
		end
	end

	// ==========================================================
	// shown-frame selection at frame boundaries
	dlwc_frame_sel u_frame_sel (
		.clk           (CLK),
		.rst_n         (RST_N),
		.flip_mode     (dlwc_flip_type'(ovb_flip_q)),
		.frame_start   (FRAME_START),
		.show_frame1_q (show_frame1)
	);

	// ==========================================================
	// derived configuration for the fetch and compositing logic
	always_comb begin
		ovb_cfg_d = '0;
		ovb_cfg_d.frame_lines = {1'b0, ovb_height_q} + 13'h0001;
		ovb_cfg_d.stride_bytes = {ovb_stride_q, 6'h00};
		ovb_cfg_d.pix_fmt = pix_fmt;
		ovb_cfg_d.place_window = ovb_place_q;
		ovb_cfg_d.overlay_ext = ovb_overlay_q;
		ovb_cfg_d.palette_offset = {ovb_palette_q, 4'h0};
		ovb_cfg_d.show_frame1 = show_frame1;
		ovb_cfg_d.fetch_origin = show_frame1 ? origin1_view : origin0_view;
		ovb_cfg_d.disp_addr0 = disp0_view;
	end

	// registered outputs
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rdata_q <= 32'h0000_0000;
			ova_win_y_out_q <= RST_WIN;
			ova_win_w_out_q <= RST_WIN;
			ova_win_lines_q <= 13'h0001;
			ova_width_zero_q <= 1'b1;
			ovb_cfg_q <= '0;
		end else begin
			rdata_q <= rdata_d;
			ova_win_y_out_q <= ova_win_y_q;
			ova_win_w_out_q <= ova_win_w_q;
			ova_win_lines_q <= {1'b0, ova_win_h_q} + 13'h0001;
			ova_width_zero_q <= (ova_win_w_q == 12'h000);
			ovb_cfg_q <= ovb_cfg_d;
		end
	end

	// ==========================================================
	// port drive
	assign RDATA = rdata_q;
	assign OVA_WIN_Y = ova_win_y_out_q;
	assign OVA_WIN_W = ova_win_w_out_q;
	assign OVA_WIN_LINES = ova_win_lines_q;
	assign OVA_WIDTH_ZERO = ova_width_zero_q;
	assign OVB_CFG = ovb_cfg_q;

endmodule : dlwc_regs

// ### tb/dlwc_regs_props.sv
// checker on the overlay register bank ports
// assumes one clock, sync active-low reset, bound onto dlwc_regs
`timescale 1ns/100ps
module dlwc_regs_props (
	input wire logic                       CLK,
	input wire logic                       RST_N,
	input wire dlwc_pkg::dlwc_bus_req_type BUS_REQ,
	input wire logic                       FRAME_START,
	input wire logic [31:0]                RDATA,
	input wire logic [11:0]                OVA_WIN_Y,
	input wire logic [11:0]                OVA_WIN_W,
	input wire logic [12:0]                OVA_WIN_LINES,
	input wire logic                       OVA_WIDTH_ZERO,
	input wire dlwc_pkg::dlwc_ovb_cfg_type OVB_CFG
);
	import dlwc_pkg::*;
	// ==========================================================
	// access decodes
	wire        wr_y = BUS_REQ.wr && BUS_REQ.addr == OFF_OVA_WIN_Y;
	wire        wr_h = BUS_REQ.wr && BUS_REQ.addr == OFF_OVA_WIN_H;
	wire        wr_m = BUS_REQ.wr && BUS_REQ.addr == OFF_OVB_MODE;
	wire        wr_e = BUS_REQ.wr && BUS_REQ.addr == OFF_OVB_EXT_MODE;
	wire        rd_w = BUS_REQ.rd && BUS_REQ.addr inside {OFF_OVA_WIN_Y, OFF_OVA_WIN_W};
	wire [31:0] wd   = BUS_REQ.wdata;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// ==========================================================
	// assertions
	a_rdata_idle: assert property (!$past(BUS_REQ.rd) |-> RDATA == 32'h0)
		else $error("read data outside answer cycle");
	a_winy_follow: assert property (wr_y |-> ##2 OVA_WIN_Y == $past(wd[11:0], 2))
		else $error("window y not taken");
	a_width_flag: assert property (OVA_WIDTH_ZERO == (OVA_WIN_W == 12'h000))
		else $error("width zero flag wrong");
	a_win_lines: assert property (wr_h |-> ##2
		OVA_WIN_LINES == {1'b0, $past(wd[11:0], 2)} + 13'h1)
		else $error("window lines not height plus one");
	a_frame_lines: assert property (wr_m |-> ##2
		OVB_CFG.frame_lines == {1'b0, $past(wd[11:0], 2)} + 13'h1)
		else $error("frame lines not height plus one");
	a_stride_unit: assert property (wr_m |-> ##2
		OVB_CFG.stride_bytes == {$past(wd[23:16], 2), 6'h0})
		else $error("stride not 64 byte units");
	a_ext_fields: assert property (wr_e |-> ##2
		OVB_CFG.palette_offset == {$past(wd[23:20], 2), 4'h0}
		&& OVB_CFG.place_window == $past(wd[0], 2) && OVB_CFG.overlay_ext == $past(wd[1], 2))
		else $error("extended mode fields wrong");
	a_origin_align: assert property (OVB_CFG.fetch_origin[3:0] == 4'h0)
		else $error("origin not 16 byte aligned");
	a_disp_align: assert property (OVB_CFG.pix_fmt == PIX_DIR16 |-> !OVB_CFG.disp_addr0[0])
		else $error("display address odd in 16 bit mode");
	a_show_boundary: assert property ($changed(OVB_CFG.show_frame1) |-> $past(FRAME_START, 2))
		else $error("shown frame changed off boundary");
	a_win_rsvd: assert property (rd_w |=> RDATA[31:12] == 20'h0)
		else $error("reserved window bits read high");
	// main scenarios
	c_mode_wr: cover property (wr_m);
	c_show_one: cover property ($rose(OVB_CFG.show_frame1));
	c_read_data: cover property (BUS_REQ.rd ##1 RDATA != 32'h0);
endmodule : dlwc_regs_props

bind dlwc_regs dlwc_regs_props u_props (.CLK(CLK), .RST_N(RST_N), .BUS_REQ(BUS_REQ),
	.FRAME_START(FRAME_START), .RDATA(RDATA), .OVA_WIN_Y(OVA_WIN_Y), .OVA_WIN_W(OVA_WIN_W),
	.OVA_WIN_LINES(OVA_WIN_LINES), .OVA_WIDTH_ZERO(OVA_WIDTH_ZERO), .OVB_CFG(OVB_CFG));

// ### tb/dlwc_regs_tb.sv
// self-checking bench for the overlay register bank
// assumes dlwc_regs alone, checker bound from its own file
`timescale 1ns/100ps
module dlwc_regs_tb;
	import dlwc_pkg::*;
	// ==========================================================
	// signals and map tables
	logic             clk;
	logic             rst_n;
	logic             frame_start;
	dlwc_bus_req_type req;
	logic [31:0]      rdata;
	logic [11:0]      win_y;
	logic [11:0]      win_w;
	logic [12:0]      win_lines;
	logic             width_zero;
	dlwc_ovb_cfg_type cfg;
	int               fail_count;
	int               n_compared;
	localparam logic [8:0] ADDRS [9] = '{OFF_OVB_MODE, OFF_OVB_ORIGIN0, OFF_OVB_DISP0,
		OFF_OVB_ORIGIN1, OFF_OVA_WIN_Y, OFF_OVA_WIN_W, OFF_OVA_WIN_H, OFF_OVB_EXT_MODE, 9'h100};
	localparam logic [31:0] MASKS [9] = '{32'he0ff0fff, 32'h03fffff0, 32'h03fffffe,
		32'h03fffff0, 32'h00000fff, 32'h00000fff, 32'h00000fff, 32'h00f00003, 32'h0};

	dlwc_regs u_dut (.CLK(clk), .RST_N(rst_n), .BUS_REQ(req), .FRAME_START(frame_start),
		.RDATA(rdata), .OVA_WIN_Y(win_y), .OVA_WIN_W(win_w), .OVA_WIN_LINES(win_lines),
		.OVA_WIDTH_ZERO(width_zero), .OVB_CFG(cfg));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========================================================
	// bus, pulse and compare tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic bus_wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk);
		req <= '0;
	endtask : bus_wr

	task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t output %h expected %h", $time, got, exp);
		end
	endtask : chk_out

	task automatic chk_rd(input logic [8:0] a, input logic [31:0] exp);
		@(posedge clk);
		req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk);
		req <= '0;
		#1;
		n_compared++;
		if (rdata !== exp) begin
			fail_count++;
			$display("[FAIL] %0t read %h at %h expected %h", $time, rdata, a, exp);
		end
	endtask : chk_rd

	task automatic pulse;
		@(posedge clk);
		frame_start <= 1'b1;
		@(posedge clk);
		frame_start <= 1'b0;
		tick(1);
	endtask : pulse

	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// ==========================================================
	// scenarios
	task automatic s_reset;
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 9; i++) chk_rd(ADDRS[i], 32'h0);
		chk_out(32'({win_lines, width_zero}), 32'h3);
		chk_out(32'({win_y, win_w}), 32'h0);
		chk_out(32'(cfg.frame_lines), 32'h1);
		chk_out(32'({cfg.pix_fmt, cfg.palette_offset}), 32'h0);
		chk_out(32'({cfg.place_window, cfg.overlay_ext, cfg.show_frame1}), 32'h0);
		chk_out(32'(cfg.fetch_origin), 32'h0);
	endtask : s_reset

	task automatic s_map;
		for (int i = 0; i < 9; i++) bus_wr(ADDRS[i], i == 7 ? 32'h3fffffff : 32'hffffffff);
		for (int i = 0; i < 9; i++) chk_rd(ADDRS[i], MASKS[i]);
	endtask : s_map

	task automatic s_colour;
		logic [1:0]       ec [4];
		dlwc_pix_fmt_type pf [4];
		ec = '{2'b00, 2'b00, 2'b01, 2'b10};
		pf = '{PIX_IDX8, PIX_DIR16, PIX_DIR24, PIX_RESERVED};
		bus_wr(OFF_OVB_DISP0, 32'h03ffffff);
		for (int i = 0; i < 4; i++) begin
			bus_wr(OFF_OVB_MODE, {i[1] ^ i[0], 7'h0, 8'(255 - i), 4'h0, 12'(4095 - i)});
			bus_wr(OFF_OVB_EXT_MODE, {ec[i], 6'h0, 4'(15 - i), 18'h0, i[1], i[0]});
			tick(1);
			chk_out(32'(cfg.frame_lines), 32'(4096 - i));
			chk_out(32'(cfg.stride_bytes), 32'((255 - i) * 64));
			chk_out(32'(cfg.pix_fmt), 32'(pf[i]));
			chk_out(32'(cfg.palette_offset), 32'((15 - i) * 16));
			chk_out(32'({cfg.overlay_ext, cfg.place_window}), 32'(i[1:0]));
			chk_out(32'(cfg.disp_addr0), pf[i] == PIX_DIR16 ? 32'h3fffffe : 32'h3ffffff);
		end
	endtask : s_colour

	task automatic s_window;
		bus_wr(OFF_OVA_WIN_Y, 32'hfffff09c);
		bus_wr(OFF_OVA_WIN_W, 32'h0000_00a5);
		bus_wr(OFF_OVA_WIN_H, 32'h0);
		tick(1);
		chk_out(32'({win_y, width_zero, win_lines}), {6'h0, 12'h09c, 1'b0, 13'h1});
		chk_out(32'(win_w), 32'h0000_00a5);
		chk_rd(OFF_OVA_WIN_Y, 32'h09c);
		bus_wr(OFF_OVA_WIN_W, 32'h1);
		bus_wr(OFF_OVA_WIN_H, 32'hfff);
		tick(1);
		chk_out(32'({width_zero, win_lines}), 32'h1000);
		chk_out(32'(win_w), 32'h1);
	endtask : s_window

	task automatic s_flip;
		logic [1:0] code [6];
		logic       show;
		code = '{2'b10, 2'b10, 2'b01, 2'b00, 2'b01, 2'b11};
		show = 1'b0;
		bus_wr(OFF_OVB_ORIGIN0, 32'h0123456f);
		bus_wr(OFF_OVB_ORIGIN1, 32'hffabcdef);
		for (int i = 0; i < 6; i++) begin
			bus_wr(OFF_OVB_MODE, {1'b0, code[i], 29'h0});
			tick(1);
			chk_out(32'(cfg.show_frame1), 32'(show));
			if (code[i] != 2'b11)
				show = code[i] == 2'b10 ? !show : code[i][0];
			pulse;
			chk_out(32'(cfg.show_frame1), 32'(show));
			chk_out(32'(cfg.fetch_origin), show ? 32'h3abcde0 : 32'h1234560);
		end
	endtask : s_flip

	// main sequence, second reset after the last scenario
	initial begin
		req = '0;
		frame_start = 1'b0;
		rst_n = 1'b0;
		fail_count = 0;
		n_compared = 0;
		s_reset();
		s_map();
		s_colour();
		s_window();
		s_flip();
		@(posedge clk);
		s_reset();
		conclude();
	end

	// hang guard
	initial begin
		#2000000;
		fail_count++;
		conclude();
	end
endmodule : dlwc_regs_tb
